/* logic/gpx_port.sv */
/*
 * Eight-pin general-purpose port expander core. Holds the output latches
 * and per-pin direction, and serves one access per request with an answer
 * one clock later.
 * Assumes the serial front end has already turned each bus transaction
 * into one request pulse, and that pin_in is synchronous to clk.
 */
// Function
// - Width query returns eight.
// - Mask query returns 0xFF.
// - Single bit write drives that pin only.
// - Single bit read makes that pin input.
// - Whole latch write sets all outputs, loads byte.
// - Whole latch read returns latches, keeps direction.
// - Single latch write: pin output, latch bit.
// - Single latch read returns latch bit, keeps direction.
// - Whole input read: all inputs, return pins.
// - Single input read: pin input, return level.
// - Whole data access aliases latch write/input read.
// - Single data access aliases latch/input single.
// - Direction read: one per pin, input=1.
// - Single direction read: input=1, output=0.
// - Respond only at bus address, default 0x48.
module gpx_port
    import gpx_pkg::*;
#(
    parameter logic [7:0] BUS_ADDR = GPX_BUS_ADDR_DEFAULT
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Request
    input wire logic req,
    input wire logic [7:0] req_addr,
    input wire logic [3:0] req_op,
    input wire logic req_write,
    input wire logic [2:0] req_pin,
    input wire logic [7:0] req_wdata,
    // Answer
    output logic ack,
    output logic nak,
    output logic [7:0] rdata,
    // Pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);

    // ----------------------------------------------------------------
    // Address match and decode
    // ----------------------------------------------------------------
    wire logic addr_hit = (req_addr == BUS_ADDR);
    wire logic take = req && addr_hit;
    logic [7:0] next_latch;
    logic [7:0] next_oe;
    logic [7:0] rd_value;
    logic refused;

    gpx_access_decode i_gpx_access_decode (
        .op(req_op),
        .write(req_write),
        .pin_sel(req_pin),
        .wdata(req_wdata),
        .latch(pin_out),
        .oe(pin_oe),
        .pins(pin_in),
        .next_latch(next_latch),
        .next_oe(next_oe),
        .rd_value(rd_value),
        .refused(refused)
    );

    // A refused write leaves state alone; an unaddressed request is ignored
    wire logic apply = take && !refused;

    // ----------------------------------------------------------------
    // Latches and drive enables
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_out <= GPX_LATCH_RESET;
            pin_oe <= GPX_OE_RESET;
        end
        else if (apply)
        begin
            pin_out <= next_latch;
            pin_oe <= next_oe;
        end
    end

    // ----------------------------------------------------------------
    // Answer, one cycle after the request
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ack <= 1'b0;
            nak <= 1'b0;
            rdata <= 8'h00;
        end
        else
        begin
            ack <= apply;
            nak <= take && refused;
            rdata <= apply ? rd_value : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    wire logic rd_req = take && !req_write;
    wire logic wr_req = take && req_write;

    a_width_value: assert property (rd_req && req_op == GPX_OP_WIDTH |=> ack && rdata == 8'h08)
        else $error("width query did not return eight");
    a_mask_value: assert property (rd_req && req_op == GPX_OP_MASK |=> ack && rdata == 8'hFF)
        else $error("mask query did not return all ones");
    a_bit_write: assert property (wr_req && req_op == GPX_OP_BIT |=>
        pin_oe[$past(req_pin)] && pin_out[$past(req_pin)] == $past(req_wdata[0])
        && (pin_oe | (8'h01 << $past(req_pin))) == ($past(pin_oe) | (8'h01 << $past(req_pin))))
        else $error("single bit write misbehaved");
    a_bit_read: assert property (rd_req && req_op == GPX_OP_BIT |=>
        !pin_oe[$past(req_pin)] && rdata == {7'h00, $past(pin_in[req_pin])})
        else $error("single bit read misbehaved");
    a_latch_write: assert property (wr_req && req_op == GPX_OP_LATCH |=>
        pin_oe == 8'hFF && pin_out == $past(req_wdata))
        else $error("whole latch write misbehaved");
    a_latch_read: assert property (rd_req && req_op == GPX_OP_LATCH |=>
        rdata == $past(pin_out) && $stable(pin_oe))
        else $error("whole latch read misbehaved");
    a_latch_n_write: assert property (wr_req && req_op == GPX_OP_LATCH_N |=>
        pin_oe[$past(req_pin)] && pin_out[$past(req_pin)] == $past(req_wdata[0]))
        else $error("single latch write misbehaved");
    a_latch_n_read: assert property (rd_req && req_op == GPX_OP_LATCH_N |=>
        rdata == {7'h00, $past(pin_out[req_pin])} && $stable(pin_oe))
        else $error("single latch read misbehaved");
    a_input_read: assert property (rd_req && req_op == GPX_OP_INPUT |=>
        pin_oe == 8'h00 && rdata == $past(pin_in))
        else $error("whole input read misbehaved");
    a_input_n_read: assert property (rd_req && req_op == GPX_OP_INPUT_N |=>
        !pin_oe[$past(req_pin)] && rdata == {7'h00, $past(pin_in[req_pin])})
        else $error("single input read misbehaved");
    a_data_write: assert property (wr_req && req_op == GPX_OP_DATA |=>
        pin_oe == 8'hFF && pin_out == $past(req_wdata))
        else $error("whole data write misbehaved");
    a_data_n_read: assert property (rd_req && req_op == GPX_OP_DATA_N |=>
        !pin_oe[$past(req_pin)] && rdata == {7'h00, $past(pin_in[req_pin])})
        else $error("single data read misbehaved");
    a_dir_read: assert property (rd_req && req_op == GPX_OP_DIR |=>
        rdata == ~$past(pin_oe) && $stable(pin_oe))
        else $error("direction read misbehaved");
    a_dir_n_read: assert property (rd_req && req_op == GPX_OP_DIR_N |=>
        rdata == {7'h00, !$past(pin_oe[req_pin])})
        else $error("single direction read misbehaved");
    a_addr_ignore: assert property (req && !addr_hit |=> !ack && !nak && $stable(pin_oe))
        else $error("answered a foreign address");
    a_reset_state: assert property ($rose(nrst) |-> pin_oe == 8'h00 && pin_out == 8'h00)
        else $error("pins not inputs after reset");

    // ----------------------------------------------------------------
    // Alias sides, side effects on other pins and refusals
    // ----------------------------------------------------------------
    // Single-pin accesses may touch one pin only; these compare the rest
    a_data_read: assert property (rd_req && req_op == GPX_OP_DATA |=>
        pin_oe == 8'h00 && rdata == $past(pin_in))
        else $error("whole data read misbehaved");
    a_data_n_write: assert property (wr_req && req_op == GPX_OP_DATA_N |=>
        pin_oe[$past(req_pin)] && pin_out[$past(req_pin)] == $past(req_wdata[0]))
        else $error("single data write misbehaved");
    a_bit_write_rest: assert property (wr_req && req_op == GPX_OP_BIT |=>
        ((pin_out ^ $past(pin_out)) & ~(8'h01 << $past(req_pin))) == 8'h00)
        else $error("single bit write touched another latch");
    a_latch_n_rest: assert property (wr_req && req_op == GPX_OP_LATCH_N |=>
        ((pin_oe ^ $past(pin_oe)) & ~(8'h01 << $past(req_pin))) == 8'h00
        && ((pin_out ^ $past(pin_out)) & ~(8'h01 << $past(req_pin))) == 8'h00)
        else $error("single latch write touched another pin");
    a_input_n_rest: assert property (rd_req && req_op == GPX_OP_INPUT_N |=>
        ((pin_oe ^ $past(pin_oe)) & ~(8'h01 << $past(req_pin))) == 8'h00
        && $stable(pin_out))
        else $error("single input read touched another pin");
    a_bit_read_rest: assert property (rd_req && req_op == GPX_OP_BIT |=>
        ((pin_oe ^ $past(pin_oe)) & ~(8'h01 << $past(req_pin))) == 8'h00)
        else $error("single bit read touched another pin");
    a_latch_read_keep: assert property (rd_req && req_op == GPX_OP_LATCH |=>
        $stable(pin_out))
        else $error("whole latch read changed the latches");
    a_latch_n_keep: assert property (rd_req && req_op == GPX_OP_LATCH_N |=>
        $stable(pin_out))
        else $error("single latch read changed the latches");
    a_dir_n_keep: assert property (rd_req && req_op == GPX_OP_DIR_N |=>
        $stable(pin_oe) && $stable(pin_out))
        else $error("single direction read changed state");
    a_config_refuse: assert property (wr_req
        && (req_op == GPX_OP_WIDTH || req_op == GPX_OP_MASK)
        |=> nak && !ack && rdata == 8'h00 && $stable(pin_oe) && $stable(pin_out))
        else $error("write to a constant was not refused");
    a_dir_refuse: assert property (wr_req
        && (req_op == GPX_OP_DIR || req_op == GPX_OP_DIR_N)
        |=> nak && !ack && $stable(pin_oe) && $stable(pin_out))
        else $error("direction write was not refused");
    a_input_refuse: assert property (wr_req
        && (req_op == GPX_OP_INPUT || req_op == GPX_OP_INPUT_N)
        |=> nak && !ack && $stable(pin_oe) && $stable(pin_out))
        else $error("input write was not refused");
    a_addr_answer: assert property (take |=> ack != nak)
        else $error("taken request got no single answer");
    a_reset_answer: assert property ($rose(nrst) |-> !ack && !nak && rdata == 8'h00)
        else $error("answer lines not idle after reset");

    c_latch_write: cover property (wr_req && req_op == GPX_OP_LATCH ##1 ack);
    c_bit_then_read: cover property (wr_req && req_op == GPX_OP_BIT ##2 rd_req
        && req_op == GPX_OP_BIT);
    c_foreign_addr: cover property (req && !addr_hit);
    c_refused: cover property (nak);
    c_dir_read: cover property (rd_req && req_op == GPX_OP_DIR_N ##1 ack);

endmodule

/* logic/gpx_pkg.sv */
/*
 * Shared constants and types for the eight-pin port expander.
 * Assumes every file that needs them imports the whole package.
 */
package gpx_pkg;

    // ----------------------------------------------------------------
    // Port geometry and reset values
    // ----------------------------------------------------------------
    localparam int GPX_WIDTH = 8;
    localparam logic [7:0] GPX_WIDTH_VALUE = 8'h08;
    localparam logic [7:0] GPX_MASK_VALUE = 8'hFF;
    localparam logic [7:0] GPX_BUS_ADDR_DEFAULT = 8'h48;
    localparam logic [7:0] GPX_LATCH_RESET = 8'h00;
    localparam logic [7:0] GPX_OE_RESET = 8'h00;
    localparam logic [7:0] GPX_ALL_OUTPUT = 8'hFF;
    localparam logic [7:0] GPX_ALL_INPUT = 8'h00;
    localparam int GPX_ANSWER_CYCLES = 1;

    // ----------------------------------------------------------------
    // Access codes carried on the request port
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        GPX_OP_WIDTH = 4'h0,
        GPX_OP_MASK = 4'h1,
        GPX_OP_BIT = 4'h2,
        GPX_OP_LATCH = 4'h3,
        GPX_OP_LATCH_N = 4'h4,
        GPX_OP_INPUT = 4'h5,
        GPX_OP_INPUT_N = 4'h6,
        GPX_OP_DATA = 4'h7,
        GPX_OP_DATA_N = 4'h8,
        GPX_OP_DIR = 4'h9,
        GPX_OP_DIR_N = 4'hA
    } gpx_op_type;

endpackage

/* logic/gpx_access_decode.sv */
/*
 * Combinational access decoder: from one request and the present latch,
 * drive-enable and pin state, works out the next latch and drive-enable
 * values and the byte to return.
 * Assumes the caller applies the results only for an accepted request.
 */
module gpx_access_decode
    import gpx_pkg::*;
(
    // Request
    input wire logic [3:0] op,
    input wire logic write,
    input wire logic [2:0] pin_sel,
    input wire logic [7:0] wdata,
    // Present state
    input wire logic [7:0] latch,
    input wire logic [7:0] oe,
    input wire logic [7:0] pins,
    // Results
    output logic [7:0] next_latch,
    output logic [7:0] next_oe,
    output logic [7:0] rd_value,
    output logic refused
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] n,
                                           input logic b);
        logic [7:0] r;
        r = v;
        r[n] = b;
        return r;
    endfunction

    function automatic logic [7:0] low_bit(input logic b);
        return {7'h00, b};
    endfunction

    // ----------------------------------------------------------------
    // Fold the alias accesses onto their canonical forms
    // ----------------------------------------------------------------
    wire logic single_alias = (op == GPX_OP_BIT) || (op == GPX_OP_DATA_N);
    wire logic whole_alias = (op == GPX_OP_DATA);
    wire logic [3:0] canon_op = single_alias ? (write ? GPX_OP_LATCH_N : GPX_OP_INPUT_N)
                              : whole_alias ? (write ? GPX_OP_LATCH : GPX_OP_INPUT)
                              : op;

    always_comb
    begin
        next_latch = latch;
        next_oe = oe;
        rd_value = 8'h00;
        refused = 1'b0;
        case (canon_op)
            GPX_OP_WIDTH:
            begin
                rd_value = GPX_WIDTH_VALUE;
                refused = write;
            end
            GPX_OP_MASK:
            begin
                rd_value = GPX_MASK_VALUE;
                refused = write;
            end
            GPX_OP_LATCH:
            begin
                if (write)
                begin
                    next_latch = wdata;
                    next_oe = GPX_ALL_OUTPUT;
                end
                else
                begin
                    rd_value = latch;
                end
            end
            GPX_OP_LATCH_N:
            begin
                if (write)
                begin
                    next_latch = put_bit(latch, pin_sel, wdata[0]);
                    next_oe = put_bit(oe, pin_sel, 1'b1);
                end
                else
                begin
                    rd_value = low_bit(latch[pin_sel]);
                end
            end
            GPX_OP_INPUT:
            begin
                refused = write;
                if (!write)
                begin
                    next_oe = GPX_ALL_INPUT;
                    rd_value = pins;
                end
            end
            GPX_OP_INPUT_N:
            begin
                refused = write;
                if (!write)
                begin
                    next_oe = put_bit(oe, pin_sel, 1'b0);
                    rd_value = low_bit(pins[pin_sel]);
                end
            end
            GPX_OP_DIR:
            begin
                rd_value = ~oe;
                refused = write;
            end
            GPX_OP_DIR_N:
            begin
                rd_value = low_bit(~oe[pin_sel]);
                refused = write;
            end
            default:
            begin
                refused = 1'b1;
            end
        endcase
    end

endmodule

/* testbench/gpx_host.sv */
/*
 * Behavioural model of the serial host that issues port accesses.
 * Assumes one request in flight at a time, launched just after a rising edge.
 */
module gpx_host
    import gpx_pkg::*;
(
    // Clock
    input wire logic clk,
    // Request side
    output logic req,
    output logic [7:0] req_addr,
    output logic [3:0] req_op,
    output logic req_write,
    output logic [2:0] req_pin,
    output logic [7:0] req_wdata,
    // Answer side
    input wire logic ack,
    input wire logic nak,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        req = 1'b0;
        req_addr = 8'h00;
        req_op = 4'h0;
        req_write = 1'b0;
        req_pin = 3'h0;
        req_wdata = 8'h00;
    end

    // ----------------------------------------------------------------
    // One access: pulse, then release lines to inverted values
    // ----------------------------------------------------------------
    // Released lines show inverted values so stale data cannot pass for a match
    task automatic access(input logic [7:0] addr, input logic [3:0] op, input logic wr,
        input logic [2:0] pin, input logic [7:0] wd,
        output logic a, output logic n, output logic [7:0] rd);
        @(posedge clk);
        req <= 1'b1;
        req_addr <= addr;
        req_op <= op;
        req_write <= wr;
        req_pin <= pin;
        req_wdata <= wd;
        @(posedge clk);
        req <= 1'b0;
        req_addr <= ~addr;
        req_op <= ~op;
        req_write <= ~wr;
        req_pin <= ~pin;
        req_wdata <= ~wd;
        @(negedge clk);
        a = ack;
        n = nak;
        rd = rdata;
    endtask
endmodule

/* testbench/i2c_gpio_expander_port_test.sv */
/*
 * Self-checking bench for the eight-pin port core.
 * Assumes the host model drives requests and an external pin level sits behind undriven pins.
 */
module i2c_gpio_expander_port_test
    import gpx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, nrst, req, req_write, ack, nak, a, n;
    logic [7:0] req_addr, req_wdata, rdata, pin_in, pin_out, pin_oe, ext, rd;
    logic [3:0] req_op;
    logic [2:0] req_pin;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    // Driven pins read back their own latch, the rest see the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

    gpx_port i_gpx_port (.clk(clk), .nrst(nrst), .req(req), .req_addr(req_addr),
        .req_op(req_op), .req_write(req_write), .req_pin(req_pin), .req_wdata(req_wdata),
        .ack(ack), .nak(nak), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));
    gpx_host i_gpx_host (.clk(clk), .req(req), .req_addr(req_addr), .req_op(req_op),
        .req_write(req_write), .req_pin(req_pin), .req_wdata(req_wdata), .ack(ack),
        .nak(nak), .rdata(rdata));

    always #25 clk = ~clk;

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Generous ceiling: the sequence needs well under 200 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            stop_test();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ----------------------------------------------------------------
    // Accepted access with expected answer and pin state
    // ----------------------------------------------------------------
    task automatic run(input logic [3:0] op, input logic wr, input logic [2:0] pin,
        input logic [7:0] wd, input logic [7:0] e_rd, input logic [7:0] e_oe,
        input logic [7:0] e_out);
        i_gpx_host.access(GPX_BUS_ADDR_DEFAULT, op, wr, pin, wd, a, n, rd);
        chk("ack nak", 8'h02, {6'h00, a, n});
        chk("rdata", e_rd, rd);
        chk("pin_oe", e_oe, pin_oe);
        chk("pin_out", e_out, pin_out);
    endtask

    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        ext = 8'h00;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("pin_oe", 8'h00, pin_oe);
        chk("pin_out", 8'h00, pin_out);
        chk("ack nak", 8'h00, {6'h00, ack, nak});
        run(GPX_OP_WIDTH, 1'b0, 3'h0, 8'h00, 8'h08, 8'h00, 8'h00);
        run(GPX_OP_MASK, 1'b0, 3'h0, 8'h00, 8'hFF, 8'h00, 8'h00);
        i_gpx_host.access(GPX_BUS_ADDR_DEFAULT, GPX_OP_WIDTH, 1'b1, 3'h0, 8'h00, a, n, rd);
        chk("ack nak", 8'h01, {6'h00, a, n});
        i_gpx_host.access(8'h49, GPX_OP_LATCH, 1'b1, 3'h0, 8'h33, a, n, rd);
        chk("ack nak", 8'h00, {6'h00, a, n});
        chk("pin_oe", 8'h00, pin_oe);
        run(GPX_OP_LATCH, 1'b1, 3'h0, 8'h5A, 8'h00, 8'hFF, 8'h5A);
        @(posedge clk);
        ext <= 8'hC3;
        run(GPX_OP_LATCH, 1'b0, 3'h0, 8'h00, 8'h5A, 8'hFF, 8'h5A);
        run(GPX_OP_DIR, 1'b0, 3'h0, 8'h00, 8'h00, 8'hFF, 8'h5A);
        run(GPX_OP_INPUT_N, 1'b0, 3'h2, 8'h00, 8'h00, 8'hFB, 8'h5A);
        run(GPX_OP_DIR_N, 1'b0, 3'h2, 8'h00, 8'h01, 8'hFB, 8'h5A);
        run(GPX_OP_DIR_N, 1'b0, 3'h3, 8'h00, 8'h00, 8'hFB, 8'h5A);
        run(GPX_OP_DIR, 1'b0, 3'h0, 8'h00, 8'h04, 8'hFB, 8'h5A);
        run(GPX_OP_LATCH_N, 1'b0, 3'h1, 8'h00, 8'h01, 8'hFB, 8'h5A);
        run(GPX_OP_BIT, 1'b1, 3'h2, 8'h01, 8'h00, 8'hFF, 8'h5E);
        run(GPX_OP_BIT, 1'b0, 3'h0, 8'h00, 8'h00, 8'hFE, 8'h5E);
        run(GPX_OP_LATCH_N, 1'b1, 3'h7, 8'h01, 8'h00, 8'hFE, 8'hDE);
        run(GPX_OP_DATA, 1'b0, 3'h0, 8'h00, 8'hDF, 8'h00, 8'hDE);
        @(posedge clk);
        ext <= 8'h3C;
        run(GPX_OP_INPUT, 1'b0, 3'h0, 8'h00, 8'h3C, 8'h00, 8'hDE);
        run(GPX_OP_DATA, 1'b1, 3'h0, 8'hA5, 8'h00, 8'hFF, 8'hA5);
        run(GPX_OP_DATA_N, 1'b1, 3'h0, 8'h00, 8'h00, 8'hFF, 8'hA4);
        run(GPX_OP_DATA_N, 1'b0, 3'h5, 8'h00, 8'h01, 8'hDF, 8'hA4);
        i_gpx_host.access(GPX_BUS_ADDR_DEFAULT, GPX_OP_INPUT, 1'b1, 3'h0, 8'h00, a, n, rd);
        chk("ack nak", 8'h01, {6'h00, a, n});
        chk("pin_oe", 8'hDF, pin_oe);
        i_gpx_host.access(GPX_BUS_ADDR_DEFAULT, GPX_OP_DIR_N, 1'b1, 3'h5, 8'h01, a, n, rd);
        chk("ack nak", 8'h01, {6'h00, a, n});
        chk("pin_out", 8'hA4, pin_out);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("pin_oe", 8'h00, pin_oe);
        chk("pin_out", 8'h00, pin_out);
        run(GPX_OP_DIR, 1'b0, 3'h0, 8'h00, 8'hFF, 8'h00, 8'h00);
        stop_test();
    end
endmodule
